/* hdl/iepl_gate.sv */
// Enable gating, level formation and level-disable filtering for twelve sources
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
module iepl_gate #(
  parameter int N = iepl_pkg::N_SRC
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  iepl_cfg_if.gate          cfg,
  input  wire logic         global_irq_gate,
  input  wire logic [6:0]   enable_first,
  input  wire logic [6:0]   prio_high_first,
  input  wire logic         level_one_disable,
  input  wire logic [7:0]   prio_high_second,
  input  wire logic         level_three_disable,
  input  wire logic [N-1:0] irq_flag,
  output logic [N-1:0]      irq_present,
  output logic [N*2-1:0]    irq_level
);
  logic [N-1:0]   en_bit;
  logic [N-1:0]   lo_bit;
  logic [N-1:0]   hi_bit;
  logic [3:0]     lvl_dis;
  logic [N-1:0]   present_nxt;
  logic [N*2-1:0] level_nxt;

  assign lvl_dis = {level_three_disable,
                    cfg.prio_l2[iepl_pkg::BIT_LVL_DIS],  // RULE7
                    level_one_disable,
                    cfg.prio_l1[iepl_pkg::BIT_LVL_DIS]}; // RULE6

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      if (g < iepl_pkg::N_OLD) begin : g_old
        assign en_bit[g] = enable_first[g];
        assign lo_bit[g] = cfg.prio_l1[g];    // RULE8
        assign hi_bit[g] = prio_high_first[g]; // RULE13
      end else begin : g_new
        assign en_bit[g] = cfg.enable2[iepl_pkg::new_bit(g)]; // RULE1
        assign lo_bit[g] = cfg.prio_l2[iepl_pkg::new_bit(g)]; // RULE9
        assign hi_bit[g] = prio_high_second[iepl_pkg::new_bit(g)]; // RULE13
      end
      // RULE2 RULE3 RULE4 RULE5 RULE14
      assign present_nxt[g] = irq_flag[g] & en_bit[g] & global_irq_gate
                              & ~lvl_dis[{hi_bit[g], lo_bit[g]}];
      assign level_nxt[g*2 +: 2] = {hi_bit[g], lo_bit[g]}; // RULE11
    end
  endgenerate

  // Registered so the arbiter polls values from the previous cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_present <= '0;
      irq_level   <= '0;
    end else begin
      irq_present <= present_nxt;
      irq_level   <= level_nxt;
    end
  end

  property p_adc_gate;
    @(posedge clk) disable iff (!rst_n)
      !(cfg.enable2[5] && global_irq_gate) |=> !irq_present[iepl_pkg::SRC_ADC];
  endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("ADC passed while gated"); // RULE2

  property p_spi_gate;
    @(posedge clk) disable iff (!rst_n)
      (irq_flag[iepl_pkg::SRC_SPI] && cfg.enable2[2] && global_irq_gate
       && lvl_dis == 4'h0) |=> irq_present[iepl_pkg::SRC_SPI];
  endproperty
  a_spi_gate: assert property (p_spi_gate) else $error("SPI request dropped"); // RULE3

  property p_two_wire_gate;
    @(posedge clk) disable iff (!rst_n)
      !cfg.enable2[1] |=> !irq_present[iepl_pkg::SRC_TWO_WIRE];
  endproperty
  a_two_wire_gate: assert property (p_two_wire_gate) else $error("Two-wire passed while off"); // RULE4

  // Keyboard and comparator are checked apart so that one leaking alone still fires
  property p_kbd_gate;
    @(posedge clk) disable iff (!rst_n)
      !(cfg.enable2[0] && global_irq_gate) |=> !irq_present[iepl_pkg::SRC_KBD];
  endproperty
  a_kbd_gate: assert property (p_kbd_gate) else $error("Keyboard passed while gated"); // RULE5

  property p_cmp_gate;
    @(posedge clk) disable iff (!rst_n)
      !(cfg.enable2[4] && global_irq_gate) |=> !irq_present[iepl_pkg::SRC_CMP];
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("Comparator passed while gated"); // RULE5

  // Timer one is watched since it is the older source that commonly sits at level 0
  property p_lvl0_off;
    @(posedge clk) disable iff (!rst_n)
      cfg.prio_l1[7] ##1 (irq_level[7:6] == 2'b00) |-> !irq_present[3];
  endproperty
  a_lvl0_off: assert property (p_lvl0_off) else $error("Level 0 not suppressed"); // RULE6

  property p_lvl2_off;
    @(posedge clk) disable iff (!rst_n)
      cfg.prio_l2[7] ##1 (irq_level[23:22] == 2'b10) |-> !irq_present[iepl_pkg::SRC_ADC];
  endproperty
  a_lvl2_off: assert property (p_lvl2_off) else $error("Level 2 not suppressed"); // RULE7

  property p_level_form;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> irq_level[19:18] == $past({prio_high_second[2], cfg.prio_l2[2]});
  endproperty
  a_level_form: assert property (p_level_form) else $error("SPI level wrong"); // RULE11
endmodule // iepl_gate

/* hdl/iepl_pkg.sv */
// Package for the interrupt enable and low-priority register slice
// How it works
// RULE1 - Second enable register: ADC b5, comparator b4, SPI b2, two-wire b1, keyboard b0.
// RULE2 - ADC request passes only with its enable and global gate both set.
// RULE3 - SPI request passes only with its enable and global gate both set.
// RULE4 - Two-wire request passes only with its enable and global gate both set.
// RULE5 - Keyboard and comparator requests pass only with enable and global gate set.
// RULE6 - Bit 7 of first low-priority register suppresses all level 0 interrupts.
// RULE7 - Bit 7 of second low-priority register suppresses all level 2 interrupts.
// RULE8 - First low-priority register holds low bits of the seven older sources.
// RULE9 - Second low-priority register holds low bits of the five newer sources.
// RULE10 - Reset clears the enable and both low-priority registers to zero.
// RULE11 - Level is high bit then low bit: 00 lowest up to 11 highest.
// RULE12 - No vector while equal or higher level is already in service.
// RULE13 - High bits come from high registers; their bit 7 disables levels 1 and 3.
// RULE14 - Request reaches arbiter only if flag, enable, global set and level allowed.
// RULE15 - Unused bits read zero and ignore writes.
package iepl_pkg;
  localparam int          N_SRC        = 12;
  localparam int          N_OLD        = 7;
  localparam logic [7:0]  OFS_ENABLE2  = 8'hb1;
  localparam logic [7:0]  OFS_PRIO_L2  = 8'hb2;
  localparam logic [7:0]  OFS_PRIO_L1  = 8'hb8;
  localparam logic [7:0]  RST_VAL      = 8'h00;
  localparam logic [7:0]  MASK_ENABLE2 = 8'h37;
  localparam logic [7:0]  MASK_PRIO_L2 = 8'hb7;
  localparam logic [7:0]  MASK_PRIO_L1 = 8'hff;
  localparam int          BIT_LVL_DIS  = 7;
  localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;
  // Source index: 0..6 older sources, 7..11 keyboard, two-wire, spi, comparator, adc
  localparam int          SRC_KBD = 7;
  localparam int          SRC_TWO_WIRE = 8;
  localparam int          SRC_SPI = 9;
  localparam int          SRC_CMP = 10;
  localparam int          SRC_ADC = 11;
  typedef enum logic [1:0] {IEPL_L0, IEPL_L1, IEPL_L2, IEPL_L3} iepl_level_e;
  // Bit position in the 8-bit register for each newer source
  function automatic int new_bit(input int s);
    case (s)
      SRC_KBD: return 0;
      SRC_TWO_WIRE: return 1;
      SRC_SPI: return 2;
      SRC_CMP: return 4;
      default: return 5;
    endcase
  endfunction
endpackage

/* hdl/iepl_cfg_if.sv */
// Interface carrying register contents from the bus slave to the gating logic
`timescale 1ns/1ns
interface iepl_cfg_if;
  logic [7:0] enable2;
  logic [7:0] prio_l1;
  logic [7:0] prio_l2;
  modport regs (output enable2, output prio_l1, output prio_l2);
  modport gate (input enable2, input prio_l1, input prio_l2);
endinterface

/* hdl/iepl_regs.sv */
// Avalon-MM register slave for the second enable and both low-priority registers
`timescale 1ns/1ns
module iepl_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  iepl_cfg_if.regs         cfg
);
  logic [7:0] enable2_r;
  logic [7:0] prio_l1_r;
  logic [7:0] prio_l2_r;
  logic       ack_r;
  logic       wr_go;

  // One wait cycle per access: request taken on the edge where waitrequest is low
  assign waitrequest = (read | write) & ~ack_r;
  assign wr_go       = write & ack_r & byteenable[0];

  always_ff @(posedge clk) begin
    if (!rst_n) ack_r <= 1'b0;
    else        ack_r <= (read | write) & ~ack_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin // RULE10
      enable2_r <= iepl_pkg::RST_VAL;
      prio_l1_r <= iepl_pkg::RST_VAL;
      prio_l2_r <= iepl_pkg::RST_VAL;
    end else if (wr_go) begin
      unique case (address)
        iepl_pkg::OFS_ENABLE2: enable2_r <= writedata[7:0] & iepl_pkg::MASK_ENABLE2; // RULE15
        iepl_pkg::OFS_PRIO_L2: prio_l2_r <= writedata[7:0] & iepl_pkg::MASK_PRIO_L2; // RULE15
        iepl_pkg::OFS_PRIO_L1: prio_l1_r <= writedata[7:0] & iepl_pkg::MASK_PRIO_L1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) readdata <= iepl_pkg::RD_UNMAPPED;
    else if (read & ~ack_r) begin
      unique case (address)
        iepl_pkg::OFS_ENABLE2: readdata <= {24'h00_0000, enable2_r};
        iepl_pkg::OFS_PRIO_L2: readdata <= {24'h00_0000, prio_l2_r};
        iepl_pkg::OFS_PRIO_L1: readdata <= {24'h00_0000, prio_l1_r};
        default:               readdata <= iepl_pkg::RD_UNMAPPED;
      endcase
    end
  end

  assign cfg.enable2 = enable2_r; // RULE1
  assign cfg.prio_l1 = prio_l1_r; // RULE8
  assign cfg.prio_l2 = prio_l2_r; // RULE9

  property p_unused_zero;
    @(posedge clk) disable iff (!rst_n)
      (enable2_r & ~iepl_pkg::MASK_ENABLE2) == 8'h00 &&
      (prio_l2_r & ~iepl_pkg::MASK_PRIO_L2) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("Unused bit set"); // RULE15

  property p_reset_clear;
    @(posedge clk) !rst_n |=> (enable2_r == 8'h00 && prio_l1_r == 8'h00 && prio_l2_r == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Reset did not clear"); // RULE10

  property p_write_en2;
    @(posedge clk) disable iff (!rst_n)
      (wr_go && address == iepl_pkg::OFS_ENABLE2)
      |=> enable2_r == ($past(writedata[7:0]) & iepl_pkg::MASK_ENABLE2);
  endproperty
  a_write_en2: assert property (p_write_en2) else $error("Enable write lost"); // RULE1
endmodule // iepl_regs

/* hdl/iepl_top.sv */
// Top of the enable and low-priority slice: register slave plus request gating
`timescale 1ns/1ns
module iepl_top (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [7:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        global_irq_gate,
  input  wire logic [6:0]                  enable_first,
  input  wire logic [6:0]                  prio_high_first,
  input  wire logic                        level_one_disable,
  input  wire logic [7:0]                  prio_high_second,
  input  wire logic                        level_three_disable,
  input  wire logic [iepl_pkg::N_SRC-1:0]  irq_flag,
  output logic [iepl_pkg::N_SRC-1:0]       irq_present,
  output logic [2*iepl_pkg::N_SRC-1:0]     irq_level,
  output logic [7:0]                       irq_enable_second,
  output logic [7:0]                       irq_priority_low_first,
  output logic [7:0]                       irq_priority_low_second
);
  iepl_cfg_if cfg ();

  iepl_regs u_regs (
    .clk         (clk),
    .rst_n       (rst_n),
    .address     (avs_address),
    .read        (avs_read),
    .write       (avs_write),
    .writedata   (avs_writedata),
    .byteenable  (avs_byteenable),
    .readdata    (avs_readdata),
    .waitrequest (avs_waitrequest),
    .cfg         (cfg)
  );

  // Vectoring against the in-service level (RULE12) stays in the arbiter
  iepl_gate u_gate (
    .clk                 (clk),
    .rst_n               (rst_n),
    .cfg                 (cfg),
    .global_irq_gate     (global_irq_gate),
    .enable_first        (enable_first),
    .prio_high_first     (prio_high_first),
    .level_one_disable   (level_one_disable),
    .prio_high_second    (prio_high_second),
    .level_three_disable (level_three_disable),
    .irq_flag            (irq_flag),
    .irq_present         (irq_present),
    .irq_level           (irq_level)
  );

  assign irq_enable_second       = cfg.enable2;
  assign irq_priority_low_first  = cfg.prio_l1;
  assign irq_priority_low_second = cfg.prio_l2;
endmodule // iepl_top

/* tb/iepl_core_model.sv */
// Partner model: rest of the interrupt controller and the request sources
`timescale 1ns/1ns
module iepl_core_model (
  input  wire logic        clk,
  input  wire logic [36:0] ctl,
  output logic             global_irq_gate,
  output logic [6:0]       enable_first,
  output logic [6:0]       prio_high_first,
  output logic             level_one_disable,
  output logic [7:0]       prio_high_second,
  output logic             level_three_disable,
  output logic [11:0]      irq_flag
);
  logic [36:0] st_r = '0;
  // Core-side registers reload one clock after the bench asks, like a real register write
  always @(posedge clk) begin
    st_r <= ctl;
  end
  assign {global_irq_gate, enable_first, prio_high_first, level_one_disable,
          prio_high_second, level_three_disable, irq_flag} = st_r;
endmodule // iepl_core_model

/* tb/test_irq_enable_priority_low.sv */
// Self-checking bench for the enable and low-priority register slice
`timescale 1ns/1ns
module test_irq_enable_priority_low;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [7:0]  avs_address = '0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        global_irq_gate, level_one_disable, level_three_disable;
  logic [6:0]  enable_first, prio_high_first;
  logic [7:0]  prio_high_second, e2, p1, p2, en2_o, pl1_o, pl2_o;
  logic [11:0] irq_flag, irq_present;
  logic [23:0] irq_level;
  logic [36:0] ctl = '0;
  logic [31:0] q;
  int          fail_count = 0;
  int          checks = 0;

  iepl_core_model iepl_core_model_i (.clk(clk), .ctl(ctl), .global_irq_gate(global_irq_gate),
    .enable_first(enable_first), .prio_high_first(prio_high_first),
    .level_one_disable(level_one_disable), .prio_high_second(prio_high_second),
    .level_three_disable(level_three_disable), .irq_flag(irq_flag));
  iepl_top iepl_top_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .global_irq_gate(global_irq_gate),
    .enable_first(enable_first), .prio_high_first(prio_high_first),
    .level_one_disable(level_one_disable), .prio_high_second(prio_high_second),
    .level_three_disable(level_three_disable), .irq_flag(irq_flag),
    .irq_present(irq_present), .irq_level(irq_level), .irq_enable_second(en2_o),
    .irq_priority_low_first(pl1_o), .irq_priority_low_second(pl2_o));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until waitrequest is seen low; settled values are sampled mid-cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int   n;
    logic ok;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    n = 0;
    ok = 0;
    while (!ok && n < 20) begin
      @(negedge clk);
      ok = !avs_waitrequest;
      q = avs_readdata;
      @(posedge clk);
      n++;
    end
    if (!ok) begin
      fail_count++;
      conclude();
    end
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00, 4'hf);
    cmp(nm, {24'h0, e}, q);
  endtask

  // Expected gating and level worked out per source from the shadow registers
  task automatic chk();
    int         b;
    logic [1:0] lv;
    logic       en, dis;
    logic [11:0] ep;
    logic [23:0] el;
    @(negedge clk);
    for (int s = 0; s < 12; s++) begin
      b = s < 7 ? s : s == 7 ? 0 : s == 8 ? 1 : s == 9 ? 2 : s == 10 ? 4 : 5;
      lv = s < 7 ? {prio_high_first[b], p1[b]} : {prio_high_second[b], p2[b]};
      en = s < 7 ? enable_first[b] : e2[b];
      dis = lv == 0 ? p1[7] : lv == 1 ? level_one_disable : lv == 2 ? p2[7] : level_three_disable;
      ep[s] = irq_flag[s] & en & global_irq_gate & !dis;
      el[2*s+:2] = lv;
    end
    cmp("irq_present", {20'h0, ep}, {20'h0, irq_present});
    cmp("irq_level", {8'h0, el}, {8'h0, irq_level});
    cmp("enable port", {24'h0, e2}, {24'h0, en2_o});
    cmp("prio_low1 port", {24'h0, p1}, {24'h0, pl1_o});
    cmp("prio_low2 port", {24'h0, p2}, {24'h0, pl2_o});
    @(posedge clk);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(8'hb1, 8'h00, "enable2");
    rd(8'hb2, 8'h00, "prio_low2");
    rd(8'hb8, 8'h00, "prio_low1");
    rd(8'hb3, 8'h00, "unmapped");
    bus(1'b1, 8'hb1, 8'hff, 4'hf);
    bus(1'b1, 8'hb2, 8'hff, 4'hf);
    bus(1'b1, 8'hb8, 8'hff, 4'hf);
    bus(1'b1, 8'hb1, 8'h00, 4'he);
    rd(8'hb1, 8'h37, "enable2 mask");
    rd(8'hb2, 8'hb7, "prio_low2 mask");
    rd(8'hb8, 8'hff, "prio_low1 all");
    $display("test registers done");
    for (int i = 0; i < 32; i++) begin
      e2 = (i[0] ? 8'hff : 8'h25) & 8'h37;
      p1 = {i[1], 7'h35};
      p2 = {i[3], 7'h13};
      bus(1'b1, 8'hb1, i[0] ? 8'hff : 8'h25, 4'h1);
      bus(1'b1, 8'hb8, p1, 4'hf);
      bus(1'b1, 8'hb2, {i[3], 7'h5b}, 4'hf);
      ctl <= {i % 5 != 0, 7'h6f, 7'h53, i[2], 8'h31, i[4], i[0] ? 12'hfff : 12'hbdf};
      repeat (3) @(posedge clk);
      chk();
    end
    $display("test gating done");
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(8'hb1, 8'h00, "enable2 rerst");
    rd(8'hb8, 8'h00, "prio_low1 rerst");
    rd(8'hb2, 8'h00, "prio_low2 rerst");
    {e2, p1, p2} = '0;
    chk();
    $display("test reset done");
    conclude();
  end
endmodule // test_irq_enable_priority_low
